/* include/ude_pkg.sv */
// constants and state layout for the up/down event counter
package ude_pkg;

    // ==========================================================
    // counter geometry
    // ==========================================================
    localparam int unsigned UDE_CNT_W    = 16;   // signed count width
    localparam int unsigned UDE_NPRESET  = 4;    // number of preset triggers

    // ==========================================================
    // register offsets (byte addresses, one word each)
    // ==========================================================
    localparam logic [7:0] UDE_OFF_CTRL    = 8'h00;  // enable and mode
    localparam logic [7:0] UDE_OFF_MAX     = 8'h04;  // upper limit
    localparam logic [7:0] UDE_OFF_MIN     = 8'h08;  // lower limit
    localparam logic [7:0] UDE_OFF_PRESET0 = 8'h0C;  // presets at 0x0C..0x18
    localparam logic [7:0] UDE_OFF_COUNT   = 8'h1C;  // present count, read only
    localparam logic [7:0] UDE_OFF_STATUS  = 8'h20;  // limit flags, read only

    // ==========================================================
    // control field positions
    // ==========================================================
    localparam int unsigned UDE_CTRL_EN_BIT   = 0;   // enable counting
    localparam int unsigned UDE_CTRL_MODE_BIT = 1;   // 0 stop, 1 roll over

    // ==========================================================
    // values after reset
    // ==========================================================
    localparam logic        UDE_RST_EN    = 1'b1;
    localparam logic        UDE_RST_MODE  = 1'b0;
    localparam logic [15:0] UDE_RST_MAX   = 16'h7FFF;
    localparam logic [15:0] UDE_RST_MIN   = 16'h8000;
    localparam logic [15:0] UDE_RST_PRE   = 16'h0000;
    localparam logic [15:0] UDE_RST_COUNT = 16'h0000;

    // ==========================================================
    // whole state of the block
    // ==========================================================
    typedef struct packed {
        logic                    en;       // counting enabled
        logic                    mode;     // roll over when set
        logic signed [15:0]      max;      // upper limit
        logic signed [15:0]      min;      // lower limit
        logic [3:0][15:0]        preset;   // preset values
        logic signed [15:0]      cnt;      // present count
        logic                    old_up;   // stored count-up trigger
        logic                    old_dn;   // stored count-down trigger
        logic                    ack;      // bus acknowledge
        logic                    err;      // bus error, unmapped address
        logic [31:0]             rdat;     // bus read data
    } ude_state_t;

endpackage

/* verilog/ude_counter.sv */
// signed 16-bit up/down event counter with limits, rollover and presets
// Function
// - enabled rising count-up edge adds one unless a count-down edge or a preset trigger coincides
// - enabled rising count-down edge subtracts one unless a count-up edge or a preset trigger coincides
// - count is signed 16-bit two's complement
// - at limit: mode 0 stops, 1 rolls over
// - limits from max/min, never exceeded by a count step; presets load unchecked
// - four preset triggers load their preset values
// - disabled counter ignores edges, presets still load
// - stored trigger copies detect rising edges
`timescale 1ns/100ps

module ude_counter
    import ude_pkg::*;
#(
    parameter int unsigned ADR_W = 8                // wishbone byte address width
) (
    input  wire logic                  clk_i,      // 100 MHz clock
    input  wire logic                  rst_i,      // synchronous reset, high
    input  wire logic                  ce_i,       // clock enable, freezes all state, reset still acts
    // trigger inputs from surrounding logic, same clock
    input  wire logic                  up_trig_i,     // count-up trigger
    input  wire logic                  dn_trig_i,     // count-down trigger
    input  wire logic [3:0]            preset_trig_i, // preset triggers, level
    // classic wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // results
    output logic      [15:0]           count_o      // present count, signed
);

    // ==========================================================
    // helpers
    // ==========================================================

    // one counting step in either direction, limits applied
    function automatic logic signed [15:0] ude_step(
        input logic signed [15:0] cnt,
        input logic               up,
        input logic signed [15:0] max,
        input logic signed [15:0] min,
        input logic               mode
    );
        logic signed [15:0] r;
        r = cnt;
        if (up) begin
            if (cnt >= max) begin
                r = mode ? min : max;
            end else if (cnt < min) begin
                r = min;
            end else begin
                r = cnt + 16'sd1;
            end
        end else begin
            if (cnt <= min) begin
                r = mode ? max : min;
            end else if (cnt > max) begin
                r = max;
            end else begin
                r = cnt - 16'sd1;
            end
        end
        return r;
    endfunction

    // byte-lane merge of a 16-bit register write
    function automatic logic [15:0] ude_wmerge(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sel
    );
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    ude_state_t st_q;               // registered state
    ude_state_t st_d;               // next state
    logic [7:0] adr;                // byte address, cut to 8 bits
    logic       req;                // live bus request
    logic       up_edge;            // count-up rising edge
    logic       dn_edge;            // count-down rising edge

    assign adr = 8'(wb_adr_i);
    assign req = wb_cyc_i & wb_stb_i;

    assign up_edge = up_trig_i & ~st_q.old_up;
    assign dn_edge = dn_trig_i & ~st_q.old_dn;

    // ==========================================================
    // next-state logic
    // ==========================================================
    always_comb begin
        st_d = st_q;

        // keep copies even while disabled, so held edges are not replayed
        st_d.old_up = up_trig_i;
        st_d.old_dn = dn_trig_i;

        if (preset_trig_i[0]) begin
            st_d.cnt = signed'(st_q.preset[0]);
        end else if (preset_trig_i[1]) begin
            st_d.cnt = signed'(st_q.preset[1]);
        end else if (preset_trig_i[2]) begin
            st_d.cnt = signed'(st_q.preset[2]);
        end else if (preset_trig_i[3]) begin
            st_d.cnt = signed'(st_q.preset[3]);
        end else if (st_q.en) begin
            if (up_edge && !dn_edge) begin
                st_d.cnt = ude_step(st_q.cnt, 1'b1, st_q.max, st_q.min, st_q.mode);
            end else if (dn_edge && !up_edge) begin
                st_d.cnt = ude_step(st_q.cnt, 1'b0, st_q.max, st_q.min, st_q.mode);
            end
        end

        // bus answer one cycle after the request, dropped the cycle after
        st_d.ack = 1'b0;
        st_d.err = 1'b0;
        if (req && !st_q.ack && !st_q.err) begin
            st_d.rdat = 32'h0000_0000;
            case (adr)
                UDE_OFF_CTRL: begin
                    st_d.ack = 1'b1;
                    st_d.rdat[UDE_CTRL_EN_BIT]   = st_q.en;
                    st_d.rdat[UDE_CTRL_MODE_BIT] = st_q.mode;
                end
                UDE_OFF_MAX: begin
                    st_d.ack = 1'b1;
                    st_d.rdat[15:0] = st_q.max;
                end
                UDE_OFF_MIN: begin
                    st_d.ack = 1'b1;
                    st_d.rdat[15:0] = st_q.min;
                end
                UDE_OFF_PRESET0, UDE_OFF_PRESET0 + 8'h04,
                UDE_OFF_PRESET0 + 8'h08, UDE_OFF_PRESET0 + 8'h0C: begin
                    st_d.ack = 1'b1;
                    st_d.rdat[15:0] = st_q.preset[2'(((adr - UDE_OFF_PRESET0) >> 2))];
                end
                UDE_OFF_COUNT: begin
                    st_d.ack = 1'b1;
                    st_d.rdat[15:0] = st_q.cnt;
                end
                UDE_OFF_STATUS: begin
                    // limit flags show where the count stands
                    st_d.ack = 1'b1;
                    st_d.rdat[0] = (st_q.cnt >= st_q.max);
                    st_d.rdat[1] = (st_q.cnt <= st_q.min);
                end
                default: begin
                    // unmapped: error answer, nothing stored
                    st_d.err = 1'b1;
                end
            endcase
        end

        // writes take effect on the edge where the master sees ack
        if (req && wb_we_i && st_q.ack) begin
            case (adr)
                UDE_OFF_CTRL: begin
                    if (wb_sel_i[0]) begin
                        st_d.en   = wb_dat_i[UDE_CTRL_EN_BIT];
                        st_d.mode = wb_dat_i[UDE_CTRL_MODE_BIT];
                    end
                end
                UDE_OFF_MAX: begin
                    st_d.max = signed'(ude_wmerge(st_q.max, wb_dat_i, wb_sel_i));
                end
                UDE_OFF_MIN: begin
                    st_d.min = signed'(ude_wmerge(st_q.min, wb_dat_i, wb_sel_i));
                end
                UDE_OFF_PRESET0, UDE_OFF_PRESET0 + 8'h04,
                UDE_OFF_PRESET0 + 8'h08, UDE_OFF_PRESET0 + 8'h0C: begin
                    st_d.preset[2'(((adr - UDE_OFF_PRESET0) >> 2))] =
                        ude_wmerge(st_q.preset[2'(((adr - UDE_OFF_PRESET0) >> 2))], wb_dat_i, wb_sel_i);
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q.en     <= UDE_RST_EN;
            st_q.mode   <= UDE_RST_MODE;
            st_q.max    <= UDE_RST_MAX;
            st_q.min    <= UDE_RST_MIN;
            st_q.preset <= {UDE_NPRESET{UDE_RST_PRE}};
            st_q.cnt    <= UDE_RST_COUNT;
            st_q.old_up <= 1'b0;
            st_q.old_dn <= 1'b0;
            st_q.ack    <= 1'b0;
            st_q.err    <= 1'b0;
            st_q.rdat   <= 32'h0000_0000;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs, data from flops, handshake gated by enable
    // ==========================================================
    assign wb_dat_o = st_q.rdat;
    // a frozen answer is hidden, else the master would take an ack
    // at an edge where the write cannot land, and the write is lost
    assign wb_ack_o = st_q.ack & ce_i;
    assign wb_err_o = st_q.err & ce_i;
    assign count_o  = st_q.cnt;

endmodule // ude_counter

/* verification/ude_counter_assertions.sv */
// port checker for the up/down event counter
`timescale 1ns/100ps
module ude_counter_assertions
    import ude_pkg::*;
#(
    parameter int unsigned ADR_W = 8
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             ce_i,
    input wire logic             up_trig_i,
    input wire logic             dn_trig_i,
    input wire logic [3:0]       preset_trig_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic             wb_ack_o,
    input wire logic [15:0]      count_o
);
    // ==========================================
    // shadow of settings and trigger copies
    // ==========================================
    logic                    oup_q, odn_q, en_q, mode_q;
    logic signed [15:0]      mx_q, mn_q, cnt, pv;
    logic [3:0][15:0]        pre_q;
    logic                    ue, de, pr, bs;
    assign cnt = count_o;
    assign ue  = up_trig_i & ~oup_q;
    assign de  = dn_trig_i & ~odn_q;
    assign pr  = |preset_trig_i;
    assign bs  = ce_i & ~pr & en_q;
    // lowest numbered preset wins
    always_comb begin
        pv = pre_q[0];
        for (int i = 3; i >= 0; i--) begin
            if (preset_trig_i[i]) begin
                pv = pre_q[i];
            end
        end
    end
    // writes land at the ack edge, like the design
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oup_q  <= 1'b0;
            odn_q  <= 1'b0;
            en_q   <= UDE_RST_EN;
            mode_q <= UDE_RST_MODE;
            mx_q   <= UDE_RST_MAX;
            mn_q   <= UDE_RST_MIN;
            pre_q  <= '0;
        end else if (ce_i) begin
            oup_q <= up_trig_i;
            odn_q <= dn_trig_i;
            if (wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i) begin
                case (wb_adr_i)
                    UDE_OFF_CTRL: {mode_q, en_q} <= wb_dat_i[1:0];
                    UDE_OFF_MAX: mx_q <= wb_dat_i[15:0];
                    UDE_OFF_MIN: mn_q <= wb_dat_i[15:0];
                    8'h0C, 8'h10, 8'h14, 8'h18: pre_q[wb_adr_i[4:2] - 3'd3] <= wb_dat_i[15:0];
                    default: ;
                endcase
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_up_adds: assert property (
        bs & ue & ~de & cnt >= mn_q & cnt < mx_q |=> cnt == $past(cnt) + 16'sd1) else $error("no up step");
    a_down_subs: assert property (
        bs & de & ~ue & cnt > mn_q & cnt <= mx_q |=> cnt == $past(cnt) - 16'sd1) else $error("no down step");
    a_stop_at_max: assert property (
        bs & ue & ~de & ~mode_q & cnt == mx_q |=> $stable(count_o)) else $error("passed max");
    a_roll_to_min: assert property (
        bs & ue & ~de & mode_q & cnt == mx_q |=> cnt == $past(mn_q)) else $error("no roll to min");
    a_roll_to_max: assert property (
        bs & de & ~ue & mode_q & cnt == mn_q |=> cnt == $past(mx_q)) else $error("no roll to max");
    a_preset_wins: assert property (
        ce_i & pr |=> cnt == $past(pv)) else $error("preset not loaded");
    a_off_holds: assert property (
        ce_i & ~pr & ~en_q |=> $stable(count_o)) else $error("counted while off");
    a_edges_cancel: assert property (
        ce_i & ~pr & ue & de |=> $stable(count_o)) else $error("edges did not cancel");
    a_level_quiet: assert property (
        ce_i & ~pr & ~ue & ~de |=> $stable(count_o)) else $error("count moved without edge");
    a_stop_at_min: assert property (
        bs & de & ~ue & ~mode_q & cnt == mn_q |=> $stable(count_o)) else $error("passed min");
    a_step_in_limits: assert property (
        bs & (ue ^ de) & (mn_q <= mx_q)
        |=> (cnt <= $past(mx_q)) && (cnt >= $past(mn_q))) else $error("step left limits");
    a_frozen_holds: assert property (
        ~ce_i |=> $stable(count_o)) else $error("count moved while frozen");
endmodule // ude_counter_assertions
bind ude_counter ude_counter_assertions #(.ADR_W(ADR_W)) chk_u (.clk_i, .rst_i, .ce_i, .up_trig_i,
    .dn_trig_i, .preset_trig_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .count_o);

/* verification/ude_trig_model.sv */
// trigger source standing in for the surrounding control logic
`timescale 1ns/100ps
module ude_trig_model (
    input  wire logic       clk_i,
    input  wire logic       up_req_i,
    input  wire logic       dn_req_i,
    input  wire logic [3:0] pre_req_i,
    output logic            up_trig_o     = 1'b0,
    output logic            dn_trig_o     = 1'b0,
    output logic [3:0]      preset_trig_o = 4'h0
);
    // ==========================================
    // statuses change just after an edge, like scan logic
    // ==========================================
    always @(posedge clk_i) begin
        up_trig_o     <= up_req_i;
        dn_trig_o     <= dn_req_i;
        preset_trig_o <= pre_req_i;
    end
endmodule // ude_trig_model

/* verification/tb_top.sv */
// self-checking bench for the up/down event counter
`timescale 1ns/100ps
module tb_top import ude_pkg::*;;
    logic        clk_i = 1'b0, rst_i = 1'b1, up_r = 1'b0, dn_r = 1'b0;
    logic [3:0]  pre_r = 4'h0, pre_t;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, up_t, dn_t, ack, err, e, ce = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic [15:0] count;
    int          err_total = 0, samples_checked = 0, cyc_cnt = 0;
    always #5 clk_i = ~clk_i;
    ude_trig_model src_u (.clk_i(clk_i), .up_req_i(up_r), .dn_req_i(dn_r), .pre_req_i(pre_r),
        .up_trig_o(up_t), .dn_trig_o(dn_t), .preset_trig_o(pre_t));
    ude_counter #(.ADR_W(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .up_trig_i(up_t),
        .dn_trig_i(dn_t), .preset_trig_i(pre_t), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .count_o(count));
    // ==========================================
    // shared tasks
    // ==========================================
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, x, g);
        end
    endtask
    // one classic cycle, waits for ack or err
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk_i); while (!(ack | err));
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000);
        chk("register", x, q);
    endtask
    // trigger levels held n cycles, then count compared
    task automatic tr(input logic u, input logic d, input logic [3:0] p, input int n, input logic [15:0] x);
        @(posedge clk_i);
        up_r  <= u;
        dn_r  <= d;
        pre_r <= p;
        repeat (n) @(posedge clk_i);
        up_r  <= 1'b0;
        dn_r  <= 1'b0;
        pre_r <= 4'h0;
        repeat (2) @(posedge clk_i);
        chk("count", {16'h0000, x}, {16'h0000, count});
    endtask
    // hang guard, run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            err_total++;
            finish_test;
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(UDE_OFF_CTRL, 32'h0000_0001);
        rc(UDE_OFF_MAX, 32'h0000_7FFF);
        rc(UDE_OFF_MIN, 32'h0000_8000);
        bus(1'b0, 8'h24, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, e});
        tr(1'b1, 1'b0, 4'h0, 1, 16'h0001);
        tr(1'b1, 1'b0, 4'h0, 4, 16'h0002);
        tr(1'b0, 1'b1, 4'h0, 1, 16'h0001);
        tr(1'b0, 1'b1, 4'h0, 1, 16'h0000);
        tr(1'b0, 1'b1, 4'h0, 1, 16'hFFFF);
        tr(1'b1, 1'b1, 4'h0, 1, 16'hFFFF);
        bus(1'b1, UDE_OFF_CTRL, 32'h0000_0000);
        tr(1'b1, 1'b0, 4'h0, 1, 16'hFFFF);
        tr(1'b0, 1'b0, 4'h1, 1, 16'h0000);
        bus(1'b1, UDE_OFF_CTRL, 32'h0000_0001);
        bus(1'b1, UDE_OFF_MAX, 32'h0000_0005);
        bus(1'b1, UDE_OFF_MIN, 32'h0000_FFFD);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, UDE_OFF_PRESET0 + 8'(4 * i), 32'h0000_0010 + 32'(i));
            tr(1'b0, 1'b0, 4'(1 << i), 1, 16'h0010 + 16'(i));
        end
        tr(1'b0, 1'b0, 4'hE, 1, 16'h0011);
        tr(1'b1, 1'b0, 4'h4, 1, 16'h0012);
        bus(1'b1, UDE_OFF_PRESET0 + 8'h0C, 32'h0000_0004);
        tr(1'b0, 1'b0, 4'h8, 1, 16'h0004);
        tr(1'b1, 1'b0, 4'h0, 1, 16'h0005);
        tr(1'b1, 1'b0, 4'h0, 1, 16'h0005);
        bus(1'b1, UDE_OFF_CTRL, 32'h0000_0003);
        tr(1'b1, 1'b0, 4'h0, 1, 16'hFFFD);
        tr(1'b0, 1'b1, 4'h0, 1, 16'h0005);
        bus(1'b1, UDE_OFF_CTRL, 32'h0000_0001);
        bus(1'b1, UDE_OFF_PRESET0 + 8'h08, 32'h0000_FFFD);
        tr(1'b0, 1'b0, 4'h4, 1, 16'hFFFD);
        tr(1'b0, 1'b1, 4'h0, 1, 16'hFFFD);
        bus(1'b1, UDE_OFF_COUNT, 32'h0000_0000);
        rc(UDE_OFF_COUNT, 32'h0000_FFFD);
        rc(UDE_OFF_STATUS, 32'h0000_0002);
        // enable low: an up edge inside the freeze must leave no trace
        ce <= 1'b0;
        tr(1'b1, 1'b0, 4'h0, 1, 16'hFFFD);
        ce <= 1'b1;
        tr(1'b1, 1'b0, 4'h0, 1, 16'hFFFE);
        // second reset in mid-run: upper limit and count back to reset values
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(UDE_OFF_MAX, 32'h0000_7FFF);
        chk("count after reset", 32'h0000_0000, {16'h0000, count});
        finish_test;
    end
endmodule // tb_top
